//--- tsr_pkg.sv
package tsr_pkg;

  // ==========================================
  // Bus addressing and register indexes
  localparam logic [3:0]  DEV_ADDR_HI = 4'h9;
  localparam logic [1:0]  IDX_TEMP    = 2'h0;
  localparam logic [1:0]  IDX_CFG     = 2'h1;
  localparam logic [1:0]  IDX_LOW     = 2'h2;
  localparam logic [1:0]  IDX_HIGH    = 2'h3;

  // ==========================================
  // Reset values and masks
  localparam logic [15:0] LOW_RST     = 16'h4B00;
  localparam logic [15:0] HIGH_RST    = 16'h5000;
  localparam logic [15:0] TEMP_RST    = 16'h0000;
  localparam logic [15:0] MASK_9BIT   = 16'hFF80;
  localparam logic [2:0]  FCNT_MAX    = 3'h6;

  // ==========================================
  // Timing
  localparam int          CONV_MS_9   = 25;
  localparam int          CLK_KHZ     = 100000;
  localparam int          CONV_CYC_9  = CONV_MS_9 * CLK_KHZ;

  // ==========================================
  // Types
  typedef struct packed {
    logic       req;
    logic [1:0] res;
    logic [1:0] fq;
    logic       lvl;
    logic       beh;
    logic       pd;
    logic [7:0] rsv;
  } tsr_cfg_t;

  localparam tsr_cfg_t CFG_RST = tsr_cfg_t'(16'h0000);

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_AACK = 9'h004,
    ST_IDX  = 9'h008,
    ST_IACK = 9'h010,
    ST_WDAT = 9'h020,
    ST_WACK = 9'h040,
    ST_RDAT = 9'h080,
    ST_RACK = 9'h100
  } tsr_state_t;

  // Consecutive faults needed per depth code
  function automatic logic [2:0] fq_need(input logic [1:0] fq);
    fq_need = (fq == 2'h0) ? 3'h1 : (fq == 2'h1) ? 3'h2 : (fq == 2'h2) ? 3'h4 : 3'h6;
  endfunction

  // Kept limit bits per resolution code
  function automatic logic [15:0] res_mask(input logic [1:0] res);
    res_mask = 16'($signed(MASK_9BIT) >>> res);
  endfunction

endpackage

//--- tsr_sync.sv
`timescale 1ns/1ns

module tsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ==========================================
  // Two-flop synchroniser
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // tsr_sync

//--- tsr_conv_timer.sv
`timescale 1ns/1ns

module tsr_conv_timer #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] cycles,
  output logic              busy,
  output logic              done
);

  logic [W-1:0] cnt_r;

  // ==========================================
  // Conversion countdown, done pulses as busy drops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        busy  <= 1'b1;
        cnt_r <= cycles - W'(1);
      end
      else if (busy && cnt_r == '0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else if (busy)
      begin
        cnt_r <= cnt_r - W'(1);
      end
    end
  end

endmodule // tsr_conv_timer

//--- tsr_top.sv
`timescale 1ns/1ns

module tsr_top #(
  parameter int CONV_BASE_CYC = tsr_pkg::CONV_CYC_9
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin_in,
  output logic             sda_pin_out,
  output logic             sda_pin_oe,
  input  wire logic [2:0]  pin_strapped_address_bits,
  input  wire logic [15:0] temperature_data_bits,
  input  wire logic        fault_hit,
  output logic             alert_out,
  output logic             conv_active
);
  import tsr_pkg::*;

  // ==========================================
  // Pin synchronisers and bus edges
  logic       scl_s;
  logic       sda_s;
  logic [2:0] strap_s;
  logic       scl_q_r;
  logic       sda_q_r;
  logic [1:0] strap_cnt_r;

  tsr_sync #(
    .W (5)
  ) u_sync (
    .clk    (mclk),
    .arst_n (arst_n),
    .d      ({scl_pin, sda_pin_in, pin_strapped_address_bits}),
    .q      ({scl_s, sda_s, strap_s})
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_q_r <= 1'b0;
      sda_q_r <= 1'b0;
    end
    else
    begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  // Edges held off until the synchronisers show real pin levels
  wire bus_rdy   = strap_cnt_r == 2'h3;
  wire scl_rise  = bus_rdy & scl_s & ~scl_q_r;
  wire scl_fall  = bus_rdy & ~scl_s & scl_q_r;
  wire start_det = bus_rdy & scl_s & scl_q_r & sda_q_r & ~sda_s;
  wire stop_det  = bus_rdy & scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ==========================================
  // Address strap capture after reset
  logic [2:0] strap_r;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt_r <= 2'h0;
      strap_r     <= 3'h0;
    end
    else if (strap_cnt_r != 2'h3)
    begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      strap_r     <= strap_s;
    end
  end

  // ==========================================
  // Register state
  tsr_cfg_t    cfg_r;
  logic [15:0] low_r;
  logic [15:0] high_r;
  logic [15:0] temp_r;
  logic [1:0]  idx_r;

  // ==========================================
  // Serial engine state
  tsr_state_t  state_r;
  logic [3:0]  cnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  hold_r;
  logic [7:0]  tx_r;
  logic [1:0]  nb_r;
  logic        rw_r;
  logic        ackon_r;
  logic        aph_r;
  logic        drive_r;
  logic        hi_r;

  // ==========================================
  // Decode and selection
  wire [7:0]  byte_in  = {sh_r[6:0], sda_s};
  wire        byte_end = scl_rise && cnt_r == 4'h7;
  wire        addr_hit = byte_in[7:1] == {DEV_ADDR_HI, strap_r};
  wire [15:0] mask     = res_mask(cfg_r.res);
  wire [15:0] cfg_rd   = {1'b0, cfg_r.res, cfg_r.fq, cfg_r.lvl, cfg_r.beh, cfg_r.pd, 8'h00};
  wire [15:0] rd_word  = (idx_r == IDX_TEMP) ? temp_r :
                         (idx_r == IDX_CFG)  ? cfg_rd :
                         (idx_r == IDX_LOW)  ? (low_r & mask) : (high_r & mask);
  wire        in_wdat  = byte_end && state_r == ST_WDAT;
  wire        cfg_wr   = in_wdat && idx_r == IDX_CFG && nb_r == 2'h0;
  wire        lim_wr   = in_wdat && idx_r[1] && nb_r == 2'h1;
  wire [15:0] wr_word  = {hold_r, byte_in} & mask;
  wire        low_wr   = lim_wr && idx_r == IDX_LOW;
  wire        high_wr  = lim_wr && idx_r == IDX_HIGH;
  wire        lim_chg  = (low_wr && wr_word != low_r) || (high_wr && wr_word != high_r);
  wire        rd_start = scl_fall && state_r == ST_AACK && aph_r && rw_r;

  // ==========================================
  // Conversion control
  logic        conv_busy;
  logic        conv_done;
  wire  [31:0] conv_cyc = 32'(CONV_BASE_CYC) << cfg_r.res;
  wire         conv_go  = ~conv_done & (~cfg_r.pd | cfg_r.req);
  // request accepted only when idle and down
  wire         req_set  = cfg_wr & byte_in[7] & cfg_r.pd & ~conv_busy;

  tsr_conv_timer #(
    .W (32)
  ) u_timer (
    .clk    (mclk),
    .arst_n (arst_n),
    .start  (conv_go),
    .cycles (conv_cyc),
    .busy   (conv_busy),
    .done   (conv_done)
  );

  assign conv_active = conv_busy;

  // ==========================================
  // Mode control register
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_r <= CFG_RST;
    end
    else
    begin
      // clear after one-shot, new set wins
      cfg_r.req <= (cfg_r.req & ~conv_done) | req_set;
      if (cfg_wr)
      begin
        cfg_r.res <= byte_in[6:5];
        cfg_r.fq  <= byte_in[4:3];
        cfg_r.lvl <= byte_in[2];
        cfg_r.beh <= byte_in[1];
        // pd only blocks the next start
        cfg_r.pd  <= byte_in[0];
      end
    end
  end

  // ==========================================
  // Limit and temperature registers
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_r  <= LOW_RST;
      high_r <= HIGH_RST;
      temp_r <= TEMP_RST;
    end
    else
    begin
      if (low_wr)
      begin
        low_r <= wr_word;
      end
      if (high_wr)
      begin
        high_r <= wr_word;
      end
      // result stored at end of conversion
      if (conv_done)
      begin
        temp_r <= temperature_data_bits & mask;
      end
    end
  end

  // ==========================================
  // Fault counter and alarm
  logic [2:0] fcnt_r;
  logic       alarm_r;
  logic       alert_r;

  wire [2:0] fcnt_inc = (fcnt_r == FCNT_MAX) ? FCNT_MAX : fcnt_r + 3'h1;
  wire       trip     = fault_hit && fcnt_inc >= fq_need(cfg_r.fq);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fcnt_r  <= 3'h0;
      alarm_r <= 1'b0;
      alert_r <= 1'b1;
    end
    else
    begin
      if (lim_chg)
      begin
        fcnt_r <= 3'h0;
      end
      else if (conv_done)
      begin
        fcnt_r <= fault_hit ? fcnt_inc : 3'h0;
      end
      if (!cfg_r.beh && conv_done)
      begin
        alarm_r <= trip;
      end
      else if (cfg_r.beh && conv_done && trip)
      begin
        alarm_r <= 1'b1;
      end
      else if (cfg_r.beh && rd_start)
      begin
        alarm_r <= 1'b0;
      end
      alert_r <= cfg_r.lvl ? alarm_r : ~alarm_r;
    end
  end

  assign alert_out = alert_r;

  // ==========================================
  // Serial slave engine
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      sh_r    <= 8'h00;
      hold_r  <= 8'h00;
      tx_r    <= 8'h00;
      nb_r    <= 2'h0;
      rw_r    <= 1'b0;
      ackon_r <= 1'b0;
      aph_r   <= 1'b0;
      drive_r <= 1'b0;
      hi_r    <= 1'b1;
      idx_r   <= IDX_TEMP;
    end
    else if (start_det)
    begin
      state_r <= ST_ADDR;
      cnt_r   <= 4'h0;
      nb_r    <= 2'h0;
      aph_r   <= 1'b0;
      drive_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE;
      aph_r   <= 1'b0;
      drive_r <= 1'b0;
    end
    else if (scl_rise)
    begin
      cnt_r <= cnt_r + 4'h1;
      sh_r  <= byte_in;
      unique case (state_r)
        ST_ADDR:
          if (cnt_r == 4'h7)
          begin
            ackon_r <= addr_hit;
            rw_r    <= sda_s;
            state_r <= addr_hit ? ST_AACK : ST_IDLE;
          end
        ST_IDX:
          if (cnt_r == 4'h7)
          begin
            idx_r   <= byte_in[1:0];
            ackon_r <= 1'b1;
            state_r <= ST_IACK;
          end
        ST_WDAT:
          if (cnt_r == 4'h7)
          begin
            // Temperature register is read-only
            ackon_r <= idx_r != IDX_TEMP;
            if (nb_r != 2'h2)
            begin
              nb_r <= nb_r + 2'h1;
            end
            if (nb_r == 2'h0)
            begin
              hold_r <= byte_in;
            end
            state_r <= ST_WACK;
          end
        ST_RDAT:
          if (cnt_r == 4'h7)
          begin
            state_r <= ST_RACK;
          end
        ST_RACK:
          if (sda_s)
          begin
            state_r <= ST_IDLE;
          end
          else
          begin
            // ACK after lower byte wraps to upper
            state_r <= ST_RDAT;
            cnt_r   <= 4'h0;
            tx_r    <= hi_r ? rd_word[15:8] : rd_word[7:0];
            hi_r    <= ~hi_r;
          end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      unique case (state_r)
        ST_AACK, ST_IACK, ST_WACK:
          if (!aph_r)
          begin
            aph_r   <= 1'b1;
            drive_r <= ackon_r;
          end
          else
          begin
            aph_r   <= 1'b0;
            cnt_r   <= 4'h0;
            drive_r <= 1'b0;
            if (state_r == ST_AACK && rw_r)
            begin
              state_r <= ST_RDAT;
              drive_r <= ~rd_word[15];
              tx_r    <= {rd_word[14:8], 1'b0};
              hi_r    <= 1'b0;
            end
            else
            begin
              state_r <= (state_r == ST_AACK) ? ST_IDX : ST_WDAT;
            end
          end
        ST_RDAT:
        begin
          drive_r <= ~tx_r[7];
          tx_r    <= {tx_r[6:0], 1'b0};
        end
        ST_RACK:
          drive_r <= 1'b0;
        default:
        begin
        end
      endcase
    end
  end

  // ==========================================
  // Open-drain data pin
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe  = drive_r;

endmodule // tsr_top

//--- tsr_top_assertions.sv
`timescale 1ns/1ns

// ==========
// Port checker
module tsr_top_assertions #(
  parameter int CONV_BASE_CYC = tsr_pkg::CONV_CYC_9
) (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        scl_pin,
  input wire logic        sda_pin_in,
  input wire logic        sda_pin_out,
  input wire logic        sda_pin_oe,
  input wire logic [2:0]  pin_strapped_address_bits,
  input wire logic [15:0] temperature_data_bits,
  input wire logic        fault_hit,
  input wire logic        alert_out,
  input wire logic        conv_active
);
  logic [31:0] run_r;
  logic [31:0] run_nxt;

  assign run_nxt = conv_active ? run_r + 32'h00000001 : 32'h00000000;

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      run_r <= 32'h00000000;
    else
      run_r <= run_nxt;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  a_conv_after_rst: assert property ($rose(arst_n) |-> ##[1:2] conv_active)
    else $error("no conversion after reset");
  a_oe_after_rst: assert property ($rose(arst_n) |-> !sda_pin_oe)
    else $error("data line driven after reset");
  a_alert_after_rst: assert property ($rose(arst_n) |-> alert_out)
    else $error("alarm active after reset");
  a_drain_only: assert property (sda_pin_out == 1'b0)
    else $error("data pin drives high");
  a_oe_scl_low: assert property ($changed(sda_pin_oe) |-> !scl_pin && !$past(scl_pin, 2))
    else $error("data changed while clock high");
  a_conv_min: assert property ($rose(conv_active) |-> conv_active [*8])
    else $error("conversion too short");
  a_conv_len: assert property ($fell(conv_active) |-> run_r inside {32'(CONV_BASE_CYC),
    32'(2 * CONV_BASE_CYC), 32'(4 * CONV_BASE_CYC), 32'(8 * CONV_BASE_CYC)})
    else $error("conversion length wrong");
  a_conv_max: assert property (run_r <= 32'(8 * CONV_BASE_CYC))
    else $error("conversion overran");
endmodule // tsr_top_assertions

bind tsr_top tsr_top_assertions #(.CONV_BASE_CYC(CONV_BASE_CYC)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in),
  .sda_pin_out(sda_pin_out), .sda_pin_oe(sda_pin_oe), .pin_strapped_address_bits(pin_strapped_address_bits),
  .temperature_data_bits(temperature_data_bits), .fault_hit(fault_hit), .alert_out(alert_out),
  .conv_active(conv_active)
);

//--- tsr_master.sv
`timescale 1ns/1ns

// ==========
// Two-wire bus master model
module tsr_master (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // Six clocks a phase, bus clock period 120 ns
  localparam int PH = 6;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic bit_io(input logic b, output logic r);
    hw(2);
    sda_low = !b;
    hw(PH - 2);
    scl = 1'b1;
    hw(PH);
    r   = sda;
    scl = 1'b0;
  endtask

  task automatic edge_cond(input logic first);
    hw(2);
    sda_low = !first;
    hw(PH - 2);
    scl = 1'b1;
    hw(PH);
    sda_low = first;
    hw(PH);
    scl = !first;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ok = !r;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] ix, input logic [23:0] d, input int nb,
                    output logic ok);
    logic k;
    edge_cond(1'b1);
    wbyte({4'h9, a, 1'b0}, ok);
    wbyte(ix, k);
    for (int i = 0; i < nb; i++)
      wbyte(d[23 - 8 * i -: 8], k);
    edge_cond(1'b0);
  endtask

  // read frame, last byte not acked
  task automatic rd(input logic [2:0] a, input int nb, output logic [31:0] q, output logic ok);
    logic [7:0] b;
    logic       r;
    q = 32'h0;
    edge_cond(1'b1);
    wbyte({4'h9, a, 1'b1}, ok);
    for (int i = 0; i < nb; i++)
    begin
      for (int j = 7; j >= 0; j--)
        bit_io(1'b1, b[j]);
      bit_io(i == nb - 1, r);
      q = {q[23:0], b};
    end
    edge_cond(1'b0);
  endtask
endmodule // tsr_master

//--- tsr_top_bench.sv
`timescale 1ns/1ns

// ==========
// Bench top
module tsr_top_bench;
  localparam int B = 50;
  logic        mclk   = 1'b0;
  logic        arst_n = 1'b0;
  logic        scl, sda_low, sda, oe, so, flt, alert, conv, ok;
  logic [2:0]  a;
  logic [15:0] tmp, v;
  logic [31:0] q;
  logic [31:0] rs = 32'h0000F613;
  int          failures = 0;
  int          checks_done = 0;
  int          n, hi;

  tsr_top #(.CONV_BASE_CYC(B)) dut (
    .mclk(mclk), .arst_n(arst_n), .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(so), .sda_pin_oe(oe),
    .pin_strapped_address_bits(a), .temperature_data_bits(tmp), .fault_hit(flt), .alert_out(alert),
    .conv_active(conv));
  tsr_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(sda_low));

  assign sda = !(oe && !so) && !sda_low;
  always #5 mclk = ~mclk;
  always @(negedge mclk)
    if (conv === 1'b1)
      hi++;

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic put(input logic [7:0] ix, input logic [23:0] d, input int nb);
    m.wr(a, ix, d, nb, ok);
  endtask

  task automatic get(input logic [7:0] ix, input int nb);
    put(ix, 24'h0, 0);
    m.rd(a, nb, q, ok);
  endtask

  task automatic wait_lvl(input logic l);
    for (int i = 0; i < 900 && conv !== l; i++)
      @(negedge mclk);
  endtask

  task automatic conv_end();
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    repeat (3) @(negedge mclk);
  endtask

  task automatic conv_len();
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    n = 0;
    while (conv === 1'b1 && n < 900)
    begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic hi_window(input int c);
    @(posedge mclk);
    hi = 0;
    repeat (c) @(negedge mclk);
  endtask

  initial
  begin
    q   = rnd();
    a   = q[2:0];
    tmp = 16'h0000;
    flt = 1'b0;
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    get(8'h02, 2);
    chk(q, 32'h4B00);
    get(8'h03, 2);
    chk(q, 32'h5000);
    get(8'h01, 2);
    chk(q, 32'h0000);
    m.wr(a ^ 3'h1, 8'h02, 24'h0, 0, ok);
    chk(ok, 0);
    for (int r = 0; r < 4; r++)
    begin
      q = rnd();
      v = {4'h5, q[11:0]};
      put(8'h01, {1'b0, 2'(r), 5'h00, 16'h0}, 1);
      chk(ok, 1);
      put(8'h03, {v, 8'h00}, 2);
      m.rd(a, 2, q, ok);
      chk(q, v & (16'hFFFF << (7 - r)));
      conv_len();
      chk(n, B << r);
    end
    q = rnd();
    v = {2'b00, q[13:0]} & 16'hFFF0;
    put(8'h02, {v, 8'hA5}, 3);
    put(8'h02, 24'hFFFF00, 1);
    m.rd(a, 4, q, ok);
    chk(q, {v, v});
    for (int f = 0; f < 4; f++)
    begin
      flt = 1'b0;
      put(8'h01, {3'h0, 2'(f), 3'h0, 16'h0}, 1);
      conv_end();
      chk(alert, 1);
      flt = 1'b1;
      n   = 0;
      while (alert !== 1'b0 && n < 8)
      begin
        conv_end();
        n++;
      end
      chk(n, (f == 0) ? 1 : 2 * f);
    end
    put(8'h01, {8'h04, 16'h0}, 1);
    conv_end();
    chk(alert, 1);
    flt = 1'b0;
    conv_end();
    chk(alert, 0);
    put(8'h01, {8'h02, 16'h0}, 1);
    flt = 1'b1;
    conv_end();
    flt = 1'b0;
    conv_end();
    chk(alert, 0);
    m.rd(a, 1, q, ok);
    chk(alert, 1);
    put(8'h01, {8'h01, 16'h0}, 1);
    conv_end();
    hi_window(500);
    chk(hi, 0);
    q   = rnd();
    tmp = q[15:0];
    @(posedge mclk);
    hi = 0;
    put(8'h01, {8'h81, 16'h0}, 1);
    repeat (300) @(negedge mclk);
    chk(hi, B);
    get(8'h01, 2);
    chk(q, 32'h0100);
    get(8'h00, 2);
    chk(q, tmp & 16'hFF80);
    put(8'h01, {8'h80, 16'h0}, 1);
    get(8'h01, 2);
    chk(q, 32'h0000);
    conv_len();
    chk(n, B);
    put(8'h01, {8'h09, 16'h0}, 1);
    repeat (60) @(negedge mclk);
    flt = 1'b1;
    put(8'h01, {8'h89, 16'h0}, 1);
    put(8'h03, 24'h600000, 2);
    put(8'h01, {8'h89, 16'h0}, 1);
    repeat (60) @(negedge mclk);
    chk(alert, 1);
    put(8'h01, {8'h89, 16'h0}, 1);
    repeat (60) @(negedge mclk);
    chk(alert, 0);
    report_and_stop();
  end

  initial
  begin
    #800000;
    failures++;
    report_and_stop();
  end
endmodule // tsr_top_bench
